// *** rtl/fsr_status.sv ***
// Serial flash status register, command decoder and operation timer.
// Assumes SPI mode 0 or 3 pins from an outside host, sampled by clk.
`timescale 1ns/10ps

module fsr_status import fsr_pkg::*; #(
  parameter int OP_CYCLES = OP_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe,
  output logic [7:0] status_byte,
  output logic quad_enable,
  output logic [3:0] block_protect,
  output logic [7:0] vol_param,
  output logic op_start,
  output fsr_op_s op_req,
  output logic op_done
);
  // Operation timer width
  localparam int CW = $clog2(OP_CYCLES + 1);

  // Refuse a zero operation time
  if (OP_CYCLES < 1) begin : g_chk
    $error("OP_CYCLES must be at least one");
  end

  logic [3:0] sync1_r; // First stage, read only by second
  logic [3:0] sync2_r; // Synced sck, cs_n, si, wp_n
  logic sck_d_r; // Previous synced clock
  logic cs_d_r; // Previous synced select
  logic sck_s, cs_s, si_s, wp_s;
  logic sck_rise, sck_fall, cs_rise, active;

  // Two-flop synchronisers for all pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sync1_r <= {wp_n, si, cs_n, sck};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[0];
      cs_d_r <= sync2_r[1];
    end
  end

  assign sck_s = sync2_r[0];
  assign cs_s = sync2_r[1];
  assign si_s = sync2_r[2];
  assign wp_s = sync2_r[3];
  assign active = !cs_s;
  assign sck_rise = active && sck_s && !sck_d_r;
  assign sck_fall = active && !sck_s && sck_d_r;
  assign cs_rise = cs_s && !cs_d_r;

  fsr_state_e state_r; // Frame decoder state
  logic [2:0] bitcnt_r; // Bit within byte
  logic [6:0] shin_r; // Incoming bits
  logic [7:0] opc_r; // Opcode of frame
  logic [31:0] addr_r; // Address bytes
  logic [2:0] abytes_r; // Address bytes seen
  logic [7:0] data_r; // Data byte
  logic frame_ok_r; // Frame complete
  logic [7:0] in_byte;
  logic byte_done;
  logic busy_r; // Operation running
  logic susp_r; // Operation suspended
  logic busy_flag; // Busy as software sees it
  logic latch_r; // Write enable latch
  logic [5:0] nv_r; // Lock, quad, protect bits
  logic allowed; // Opcode legal while busy
  logic needs_addr; // Opcode takes address

  assign in_byte = {shin_r, si_s};
  assign byte_done = sck_rise && bitcnt_r == 3'd7;
  assign busy_flag = busy_r && !susp_r;
  // Only reads, reset and suspend pass while busy
  assign allowed = opc_allowed(in_byte);
  assign needs_addr = in_byte == OPC_PROG || in_byte == OPC_SE
                   || in_byte == OPC_BE32 || in_byte == OPC_BE64;

  function automatic logic opc_allowed(input logic [7:0] o);
    opc_allowed = o == OPC_ST_READ || o == OPC_RDFR || o == OPC_RDERP
               || o == OPC_RSTEN || o == OPC_RST || o == OPC_SUSP;
  endfunction : opc_allowed

  // Bit and byte capture on sck rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitcnt_r <= 3'd0;
      shin_r <= 7'h00;
    end else if (!active) begin
      bitcnt_r <= 3'd0;
    end else if (sck_rise) begin
      bitcnt_r <= bitcnt_r + 3'd1;
      shin_r <= in_byte[6:0];
    end
  end

  // Frame decoder
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_CMD;
      opc_r <= 8'h00;
      addr_r <= 32'h0000_0000;
      abytes_r <= 3'd0;
      data_r <= 8'h00;
      frame_ok_r <= 1'b0;
    end else if (!active) begin
      state_r <= ST_CMD;
      abytes_r <= 3'd0;
      if (cs_rise) begin
        frame_ok_r <= 1'b0;
      end
    end else if (byte_done) begin
      unique case (state_r)
        ST_CMD: begin
          opc_r <= in_byte;
          if (busy_flag && !allowed) begin
            state_r <= ST_SKIP;
          end else if (in_byte == OPC_ST_READ) begin
            state_r <= ST_READ;
          end else if (in_byte == OPC_RDFR || in_byte == OPC_RDERP) begin
            state_r <= ST_READ;
          end else if (needs_addr) begin
            state_r <= ST_ADDR;
          end else if (in_byte == OPC_ST_WRITE || in_byte == OPC_VOLW) begin
            state_r <= ST_DATA;
          end else begin
            state_r <= ST_SKIP;
            frame_ok_r <= 1'b1;
          end
        end
        ST_ADDR: begin
          addr_r <= {addr_r[23:0], in_byte};
          abytes_r <= abytes_r + 3'd1;
          if (abytes_r == 3'(ADDR_BYTES - 1)) begin
            state_r <= ST_SKIP;
            frame_ok_r <= 1'b1;
          end
        end
        ST_DATA: begin
          data_r <= in_byte;
          state_r <= ST_SKIP;
          frame_ok_r <= 1'b1;
        end
        ST_READ, ST_SKIP: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Commands take effect when select rises
  logic exec, exec_wen, exec_wdis, exec_swrst, nv_write, exec_volw;
  logic start_op, op_finish, locked, rst_en_r;
  logic [CW-1:0] cnt_r; // Operation cycles left
  fsr_op_e kind;
  assign exec = cs_rise && frame_ok_r;
  assign locked = nv_r[5] && !wp_s;
  assign exec_wen = exec && opc_r == OPC_WR_ENABLE && !busy_r;
  assign exec_wdis = exec && opc_r == OPC_WR_DISABLE && !busy_r;
  assign exec_swrst = exec && opc_r == OPC_RST && rst_en_r;
  assign exec_volw = exec && opc_r == OPC_VOLW && !busy_r;

  // Map opcode to operation kind
  always_comb begin
    unique case (opc_r)
      OPC_PROG: kind = OP_PROG;
      OPC_SE: kind = OP_SE;
      OPC_BE32: kind = OP_BE32;
      OPC_BE64: kind = OP_BE64;
      OPC_CE: kind = (nv_r[3:0] == 4'h0) ? OP_CE : OP_NONE;
      OPC_ST_WRITE: kind = locked ? OP_NONE : OP_NVW;
      default: kind = OP_NONE;
    endcase
  end

  // Write latch gates every operation start
  assign start_op = exec && !busy_r && latch_r && kind != OP_NONE;
  assign nv_write = start_op && kind == OP_NVW;
  assign op_finish = busy_flag && cnt_r == CW'(1);

  // Operation timer, suspend and software reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      susp_r <= 1'b0;
      cnt_r <= '0;
      rst_en_r <= 1'b0;
    end else begin
      if (exec) begin
        rst_en_r <= opc_r == OPC_RSTEN;
      end
      if (exec_swrst) begin
        busy_r <= 1'b0;
        susp_r <= 1'b0;
      end else if (start_op) begin
        busy_r <= 1'b1;
        cnt_r <= CW'(OP_CYCLES);
      end else if (op_finish) begin
        busy_r <= 1'b0;
        cnt_r <= '0;
      end else if (busy_flag) begin
        cnt_r <= cnt_r - CW'(1);
        if (exec && opc_r == OPC_SUSP && op_req.kind != OP_NVW) begin
          susp_r <= 1'b1;
        end
      end else if (susp_r && exec && opc_r == OPC_RESUME) begin
        susp_r <= 1'b0;
      end
    end
  end

  // Write enable latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= 1'b0;
    end else if (exec_wen) begin
      latch_r <= 1'b1;
    end else if (exec_wdis || op_finish || exec_swrst) begin
      latch_r <= 1'b0;
    end
  end

  // Non-volatile bits, written only by status write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_r <= STATUS_RESET[7:2];
    end else if (nv_write) begin
      nv_r <= data_r[7:2];
    end
  end

  // Volatile parameter, no latch needed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vol_param <= 8'h00;
    end else if (exec_volw) begin
      vol_param <= data_r;
    end
  end

  // Operation request with decoded address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_req <= '0;
      op_start <= 1'b0;
      op_done <= 1'b0;
    end else begin
      op_start <= start_op;
      op_done <= op_finish;
      if (start_op) begin
        op_req.kind <= kind;
        op_req.sector <= addr_r[ADDR_MSB:SECT_LSB];
        op_req.blk32 <= addr_r[ADDR_MSB:BLK32_LSB];
        op_req.blk64 <= addr_r[ADDR_MSB:BLK64_LSB];
      end
    end
  end

  // Status byte layout
  assign status_byte = {nv_r, latch_r, busy_flag};
  assign quad_enable = nv_r[QUAD_BIT-BP_LSB];
  assign block_protect = nv_r[3:0];

  logic [7:0] out_sh_r; // Outgoing byte
  logic [2:0] ocnt_r; // Bits sent in byte
  logic rd_stat;
  assign rd_stat = opc_r == OPC_ST_READ;

  // Serial output on sck fall, status repeats live
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
      out_sh_r <= 8'h00;
      ocnt_r <= 3'd0;
    end else if (!active) begin
      so_oe <= 1'b0;
      ocnt_r <= 3'd0;
    end else if (byte_done && state_r == ST_CMD) begin
      out_sh_r <= (in_byte == OPC_ST_READ) ? status_byte : 8'h00;
    end else if (sck_fall && state_r == ST_READ) begin
      so_oe <= 1'b1;
      so_o <= out_sh_r[7];
      ocnt_r <= ocnt_r + 3'd1;
      if (ocnt_r == 3'd7) begin
        out_sh_r <= rd_stat ? status_byte : 8'h00;
      end else begin
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_start_busy;
    start_op |=> status_byte[BUSY_BIT] [*2];
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set");

  property p_no_start_busy;
    start_op |-> !busy_r;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");

  property p_finish;
    op_finish |=> !status_byte[BUSY_BIT] && !status_byte[LATCH_BIT] && op_done;
  endproperty
  a_finish: assert property (p_finish) else $error("finish wrong");

  property p_latch_gate;
    $rose(op_start) |-> $past(latch_r, 2);
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("op without latch");

  property p_latch_set;
    exec_wen |=> status_byte[LATCH_BIT];
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_cause;
    $changed(latch_r) |-> $past(exec_wen || exec_wdis || op_finish || exec_swrst);
  endproperty
  a_latch_cause: assert property (p_latch_cause) else $error("latch changed");

  property p_nv_cause;
    $changed(nv_r) |-> $past(nv_write) && nv_r == $past(data_r[7:2]);
  endproperty
  a_nv_cause: assert property (p_nv_cause) else $error("nv bits changed");

  property p_lock;
    exec && opc_r == OPC_ST_WRITE && nv_r[5] && !wp_s |=> $stable(nv_r) && !op_start;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");

  property p_ce;
    start_op && kind == OP_CE |-> block_protect == 4'h0;
  endproperty
  a_ce: assert property (p_ce) else $error("erase under protect");

  property p_decode;
    start_op |=> op_req.blk64 == $past(addr_r[ADDR_MSB:BLK64_LSB]);
  endproperty
  a_decode: assert property (p_decode) else $error("bad block decode");

  property p_read;
    byte_done && state_r == ST_CMD && in_byte == OPC_ST_READ |=> state_r == ST_READ;
  endproperty
  a_read: assert property (p_read) else $error("status read refused");
endmodule : fsr_status

// *** common/fsr_pkg.sv ***
// Constants, opcodes and carrier types of the flash status register block.
// Assumes a system clock of 25 MHz that samples the serial pins.
package fsr_pkg;
  // System clock period and default internal operation time
  localparam int CLK_NS = 40;
  localparam int OP_TIME_NS = 2000;
  // Least time rounds up to whole cycles
  localparam int OP_CYCLES_DEF = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
  // Status byte bit positions and value after reset
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int BP_LSB = 2;
  localparam int QUAD_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Array address field positions
  localparam int SECT_LSB = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;
  localparam int ADDR_MSB = 24;
  localparam int ADDR_BYTES = 4;
  // Command opcodes
  localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
  localparam logic [7:0] OPC_ST_READ = 8'h05;
  localparam logic [7:0] OPC_ST_WRITE = 8'h01;
  localparam logic [7:0] OPC_RDFR = 8'h48;
  localparam logic [7:0] OPC_RDERP = 8'h81;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_SE = 8'h20;
  localparam logic [7:0] OPC_BE32 = 8'h52;
  localparam logic [7:0] OPC_BE64 = 8'hD8;
  localparam logic [7:0] OPC_CE = 8'hC7;
  localparam logic [7:0] OPC_VOLW = 8'hC0;
  localparam logic [7:0] OPC_RSTEN = 8'h66;
  localparam logic [7:0] OPC_RST = 8'h99;
  localparam logic [7:0] OPC_SUSP = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7A;
  // Frame decoder states, Gray in the order declared
  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_READ = 3'h2,
    ST_SKIP = 3'h6
  } fsr_state_e;
  // Kind of internal operation
  typedef enum logic [2:0] {
    OP_NONE, OP_PROG, OP_SE, OP_BE32, OP_BE64, OP_CE, OP_NVW
  } fsr_op_e;
  // Operation request with decoded array position
  typedef struct packed {
    fsr_op_e kind;
    logic [ADDR_MSB-SECT_LSB:0] sector;
    logic [ADDR_MSB-BLK32_LSB:0] blk32;
    logic [ADDR_MSB-BLK64_LSB:0] blk64;
  } fsr_op_s;
endpackage : fsr_pkg

// *** dv/fsr_host.sv ***
// Host model: an SPI mode 0 controller that frames commands to the status block.
// Assumes the bench clock; every pin change lands just after a rising edge.
`timescale 1ns/10ps
module fsr_host (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_o
);
  // Idle: deselected, serial clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One frame of n bytes, MSB first from tx[47]; rx keeps the last byte seen
  task automatic xfer(input int n, input logic [47:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < 8 * n; i++) begin
      si <= tx[47];
      tx = tx << 1;
      tick(4);
      sck <= 1'b1;
      tick(3);
      // Sample mid-cycle so a register update cannot race the read
      @(negedge clk);
      rx = {rx[6:0], so_o};
      @(posedge clk);
      sck <= 1'b0;
    end
    tick(4);
    cs_n <= 1'b1;
    // Released line shows no stale value
    si <= ~si;
    tick(6);
  endtask : xfer
endmodule : fsr_host

// *** dv/tb_flash_status_register_map.sv ***
// Testbench: drives the status block through the host model and checks results.
// Assumes a 25 MHz clock and an operation time of 400 cycles, longer than the default of 50.
`timescale 1ns/10ps
module tb_flash_status_register_map;
  import fsr_pkg::*;
  localparam int OPC = 400;  // Busy long enough to read status mid-operation
  logic clk, rstn, sck, cs_n, si, wp_n, so_o, so_oe, quad_enable, op_start, op_done;
  logic [7:0] status_byte, vol_param, rx;
  logic [3:0] block_protect;
  fsr_op_s op_req, last_req;  // Last request seen with a start pulse
  int mismatches = 0;
  int checks = 0;
  int starts = 0;

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  fsr_status #(.OP_CYCLES(OPC)) i_dut (
    .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so_o(so_o), .so_oe(so_oe), .status_byte(status_byte), .quad_enable(quad_enable),
    .block_protect(block_protect), .vol_param(vol_param), .op_start(op_start),
    .op_req(op_req), .op_done(op_done)
  );
  fsr_host i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o));

  // Capture every started operation
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      last_req <= op_req;
      starts <= starts + 1;
    end
  end

  // Closing report
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Send a command frame
  task automatic cmd(input int n, input logic [47:0] tx);
    i_host.xfer(n, tx, rx);
  endtask : cmd

  // Read the status byte over the pins
  task automatic rd_st(input logic [7:0] exp);
    i_host.xfer(2, {OPC_ST_READ, 40'h0}, rx);
    chk({24'h0, rx}, {24'h0, exp});
  endtask : rd_st

  // Bounded wait for the end-of-operation pulse
  task automatic wait_done();
    int k;
    k = 0;
    while (op_done !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 2000) begin
        mismatches++;
        finish_test();
      end
    end
    @(posedge clk);
  endtask : wait_done

  task automatic t_reset();
    chk({24'h0, status_byte}, {24'h0, STATUS_RESET});
    chk({31'h0, so_oe}, 32'h0);
    rd_st(8'h00);
  endtask : t_reset

  task automatic t_latch();
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    rd_st(8'h02);
    cmd(1, {OPC_WR_DISABLE, 40'h0});
    rd_st(8'h00);
  endtask : t_latch

  task automatic t_stwrite();
    cmd(2, {OPC_ST_WRITE, 8'h5E, 32'h0});
    rd_st(8'h00);
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(2, {OPC_ST_WRITE, 8'h5E, 32'h0});
    rd_st(8'h5F);
    chk({28'h0, block_protect}, 32'h7);
    chk({31'h0, quad_enable}, 32'h1);
    cmd(1, {OPC_WR_DISABLE, 40'h0});
    rd_st(8'h5F);
    chk({29'h0, last_req.kind}, {29'h0, OP_NVW});
    wait_done();
    rd_st(8'h5C);
  endtask : t_stwrite

  task automatic t_ops();
    logic [7:0] opc [5] = '{OPC_PROG, OPC_SE, OPC_BE32, OPC_BE64, OPC_CE};
    fsr_op_e knd [5] = '{OP_PROG, OP_SE, OP_BE32, OP_BE64, OP_CE};
    logic [31:0] a;
    int s;
    s = starts;
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(1, {OPC_CE, 40'h0});
    chk(starts, s);
    cmd(2, {OPC_ST_WRITE, 8'h00, 32'h0});
    wait_done();
    cmd(5, {OPC_SE, 32'h01AB_C123, 8'h00});
    i_host.tick(20);
    chk(starts, s + 1);
    for (int i = 0; i < 5; i++) begin
      a = 32'h01AB_C123 + i * 32'h0013_5000;
      cmd(1, {OPC_WR_ENABLE, 40'h0});
      cmd(5, {opc[i], a, 8'h00});
      chk({29'h0, last_req.kind}, {29'h0, knd[i]});
      // Chip erase takes no address bytes, so its fields carry no meaning
      if (i < 4) begin
        chk({19'h0, last_req.sector}, {19'h0, a[24:12]});
        chk({22'h0, last_req.blk32}, {22'h0, a[24:15]});
        chk({23'h0, last_req.blk64}, {23'h0, a[24:16]});
      end
      wait_done();
    end
    rd_st(8'h00);
  endtask : t_ops

  task automatic t_lock();
    @(posedge clk);
    wp_n <= 1'b0;
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(2, {OPC_ST_WRITE, 8'h80, 32'h0});
    wait_done();
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(2, {OPC_ST_WRITE, 8'h04, 32'h0});
    i_host.tick(20);
    chk({26'h0, status_byte[7:2]}, 32'h20);
    @(posedge clk);
    wp_n <= 1'b1;
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(2, {OPC_ST_WRITE, 8'h00, 32'h0});
    wait_done();
    rd_st(8'h00);
  endtask : t_lock

  // Erase suspended and resumed, then a program cut short by software reset
  task automatic t_susp();
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(5, {OPC_SE, 32'h0000_3000, 8'h00});
    cmd(1, {OPC_SUSP, 40'h0});
    rd_st(8'h02);
    cmd(1, {OPC_RESUME, 40'h0});
    rd_st(8'h03);
    wait_done();
    rd_st(8'h00);
    cmd(1, {OPC_WR_ENABLE, 40'h0});
    cmd(5, {OPC_PROG, 32'h0000_0100, 8'h00});
    rd_st(8'h03);
    cmd(1, {OPC_RSTEN, 40'h0});
    cmd(1, {OPC_RST, 40'h0});
    rd_st(8'h00);
  endtask : t_susp

  task automatic t_vol();
    cmd(2, {OPC_VOLW, 8'hA5, 32'h0});
    chk({24'h0, vol_param}, 32'hA5);
  endtask : t_vol

  // Main sequence
  initial begin
    rstn = 1'b0;
    wp_n = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    i_host.tick(5);
    t_reset();
    t_latch();
    t_stwrite();
    t_ops();
    t_lock();
    t_susp();
    t_vol();
    finish_test();
  end
endmodule : tb_flash_status_register_map
